// ==== hdl/ccm_cache_ctrl.sv ====
module ccm_cache_ctrl #(
    parameter int LINES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ccm_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire ccm_pkg::ccm_req_t req_i,
    output logic req_ready_o,
    output ccm_pkg::ccm_rsp_t rsp_o,
    input wire ccm_pkg::ccm_snp_t snp_i,
    output logic snp_hit_o,
    output logic snp_hitm_o,
    output logic fault_o,
    output logic [15:0] fault_code_o,
    output ccm_pkg::ccm_mode_t mode_o,
    output logic strict_order_o
);
    import ccm_pkg::*;

    localparam int IDX_W = $clog2(LINES);
    localparam int LAD_W = ADDR_W - LINE_BITS;

    if (LINES < 2 || (LINES & (LINES - 1)) != 0) begin : g_bad_lines
        $error("LINES must be a power of two, at least 2");
    end

    ////////////////////////////////////////////////////////////////////
    logic coff_ff;
    logic wbi_ff;
    logic rt_en_ff;
    logic all_unc_ff;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic fault_ff;
    logic [7:0] fcnt_ff;
    logic [PG_W-1:0] page_ff;
    ccm_rsp_t rsp_ff;
    logic shit_ff;
    logic shitm_ff;
    ccm_mesi_t dstate_ff [LINES];
    logic [LAD_W-1:0] dtag_ff [LINES];
    logic ival_ff [LINES];
    logic [LAD_W-1:0] itag_ff [LINES];

    // Bus slave decode
    wire wb_go = wb_cyc_i && wb_stb_i && !ack_ff;
    wire wb_wr = wb_go && wb_we_i;
    wire ctrl_wr = wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[3];
    wire cfg_wr = wb_wr && wb_adr_i == REG_CFG && wb_sel_i[0];
    wire inv_all = wb_wr && wb_adr_i == REG_INV && wb_sel_i[0]
        && wb_dat_i[INV_ALL];
    wire bad_ctrl = ctrl_wr && !wb_dat_i[COFF_BIT] && wb_dat_i[WBI_BIT];

    // Mode follows the flags with no pipeline stage
    wire mode_nofill = coff_ff;
    wire mode_normal = !coff_ff && !wbi_ff;

    wire [31:0] ctrl_rd = {1'h0, coff_ff, wbi_ff, 29'h0};
    wire [31:0] cfg_rd = {30'h0, all_unc_ff, rt_en_ff};
    wire [31:0] stat_rd = {16'h0, fcnt_ff, 6'h0, strict_order_o,
        mode_nofill};
    wire [31:0] rd_mux = (wb_adr_i == REG_CTRL) ? ctrl_rd :
        (wb_adr_i == REG_CFG) ? cfg_rd :
        (wb_adr_i == REG_STAT) ? stat_rd : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coff_ff <= COFF_RST;
            wbi_ff <= WBI_RST;
        end else if (ctrl_wr && !bad_ctrl) begin
            coff_ff <= wb_dat_i[COFF_BIT];
            wbi_ff <= wb_dat_i[WBI_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rt_en_ff <= RT_EN_RST;
            all_unc_ff <= ALL_UNC_RST;
        end else if (cfg_wr) begin
            rt_en_ff <= wb_dat_i[CFG_RT_EN];
            all_unc_ff <= wb_dat_i[CFG_ALL_UNC];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'h0;
            dat_ff <= 32'h0;
            fault_ff <= 1'h0;
            fcnt_ff <= 8'h0;
        end else begin
            ack_ff <= wb_go;
            dat_ff <= wb_go ? rd_mux : dat_ff;
            fault_ff <= bad_ctrl;
            fcnt_ff <= fcnt_ff + {7'h0, bad_ctrl};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Core access decode
    wire [IDX_W-1:0] idx = req_i.addr[LINE_BITS +: IDX_W];
    wire [LAD_W-1:0] lad = req_i.addr[ADDR_W-1:LINE_BITS];
    wire [PG_W-1:0] pg = req_i.addr[ADDR_W-1:PAGE_BITS];
    wire [IDX_W-1:0] s_idx = snp_i.addr[LINE_BITS +: IDX_W];
    wire [LAD_W-1:0] s_lad = snp_i.addr[ADDR_W-1:LINE_BITS];

    wire d_hit = dstate_ff[idx] != MESI_I && dtag_ff[idx] == lad;
    wire i_hit = ival_ff[idx] && itag_ff[idx] == lad;
    wire s_hit = dstate_ff[s_idx] != MESI_I && dtag_ff[s_idx] == s_lad;
    wire s_ihit = ival_ff[s_idx] && itag_ff[s_idx] == s_lad;
    wire ccm_mesi_t d_st = d_hit ? dstate_ff[idx] : MESI_I;

    // A snoop to the same set holds the core off for that cycle
    assign req_ready_o = !(snp_i.valid && s_idx == idx) && !inv_all;
    wire req_fire = req_i.valid && req_ready_o;

    wire spec_unc = req_i.spec && req_i.uncached;
    wire [PG_W-1:0] page_nx = page_ff + PG_W'(1);
    wire far_page = !req_i.spec && req_i.uncached && req_i.extra
        && pg != page_ff && pg != page_nx;
    wire alloc_ok = mode_normal && !req_i.uncached;

    logic hit;
    logic refused;
    ccm_op_t op;
    logic d_upd;
    ccm_mesi_t d_new;
    logic i_fill;

    // Fetches report the instruction line, never the data line
    wire ccm_mesi_t i_st = (hit || i_fill) ? MESI_S : MESI_I;

    always_comb begin
        hit = 1'h0;
        refused = 1'h0;
        op = OP_NONE;
        d_upd = 1'h0;
        d_new = MESI_I;
        i_fill = 1'h0;
        if (req_i.fetch) begin
            if (spec_unc || far_page) begin
                refused = 1'h1;
            end else if (i_hit) begin
                hit = 1'h1;
            end else if (alloc_ok) begin
                op = OP_FILL;
                i_fill = 1'h1;
            end else begin
                op = OP_MEM_RD;
            end
        end else if (!req_i.write) begin
            if (d_hit) begin
                hit = 1'h1;
            end else if (alloc_ok) begin
                op = OP_FILL;
                d_upd = 1'h1;
                d_new = MESI_E;
            end else begin
                op = OP_MEM_RD;
            end
        end else begin
            unique case (d_st)
                MESI_M, MESI_E: begin
                    hit = 1'h1;
                    d_upd = 1'h1;
                    d_new = MESI_M;
                end
                MESI_S: begin
                    hit = 1'h1;
                    if (req_i.promote_ok) begin
                        op = OP_RD_INV;
                        d_upd = 1'h1;
                        d_new = mode_normal ? MESI_M : MESI_E;
                    end else begin
                        op = OP_MEM_WR;
                    end
                end
                MESI_I: begin
                    if (alloc_ok) begin
                        op = OP_FILL_WR;
                        d_upd = 1'h1;
                        d_new = MESI_E;
                    end else begin
                        op = OP_MEM_WR;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Line state arrays; snoops win over core updates to the same set
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < LINES; i++) begin
            if (rst_i || inv_all) begin
                dstate_ff[i] <= MESI_I;
                ival_ff[i] <= 1'h0;
            end else begin
                if (snp_i.valid && s_hit && s_idx == IDX_W'(i)) begin
                    dstate_ff[i] <= snp_i.inv ? MESI_I : MESI_S;
                end else if (req_fire && d_upd && idx == IDX_W'(i)) begin
                    dstate_ff[i] <= d_new;
                end
                if (snp_i.valid && snp_i.inv && s_ihit
                    && s_idx == IDX_W'(i)) begin
                    ival_ff[i] <= 1'h0;
                end else if (req_fire && idx == IDX_W'(i)) begin
                    if (req_i.write && !req_i.fetch && i_hit) begin
                        ival_ff[i] <= 1'h0;
                    end else if (i_fill) begin
                        ival_ff[i] <= 1'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < LINES; i++) begin
            if (rst_i) begin
                dtag_ff[i] <= '0;
                itag_ff[i] <= '0;
            end else if (req_fire && idx == IDX_W'(i)) begin
                dtag_ff[i] <= d_upd ? lad : dtag_ff[i];
                itag_ff[i] <= i_fill ? lad : itag_ff[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Page of the last accepted instruction fetch that is neither spec nor extra
    wire page_upd = req_fire && req_i.fetch && !req_i.spec
        && !req_i.extra;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page_ff <= '0;
            rsp_ff <= '0;
            shit_ff <= 1'h0;
            shitm_ff <= 1'h0;
        end else begin
            page_ff <= page_upd ? pg : page_ff;
            rsp_ff.valid <= req_fire;
            rsp_ff.hit <= req_fire && hit;
            rsp_ff.refused <= req_fire && refused;
            rsp_ff.op <= req_fire ? op : OP_NONE;
            rsp_ff.state <= req_i.fetch ? i_st : (d_upd ? d_new : d_st);
            shit_ff <= snp_i.valid && (s_hit || s_ihit);
            shitm_ff <= snp_i.valid && s_hit
                && dstate_ff[s_idx] == MESI_M;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign rsp_o = rsp_ff;
    assign snp_hit_o = shit_ff;
    assign snp_hitm_o = shitm_ff;
    assign fault_o = fault_ff;
    assign fault_code_o = FAULT_CODE;
    assign mode_o = mode_nofill ? MODE_NOFILL : MODE_NORMAL;
    // With caching off, weak ordering is only safe while range typing can mark memory
    assign strict_order_o = mode_nofill && (!rt_en_ff || all_unc_ff);

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    spec_unc_a: assert property (
        req_fire && req_i.fetch && spec_unc
        |=> rsp_o.refused && rsp_o.op == OP_NONE)
        else $error("speculative uncacheable fetch issued");

    branch_page_a: assert property (
        req_fire && req_i.fetch && req_i.spec |=> $stable(page_ff))
        else $error("speculative fetch moved the code page");

    far_page_a: assert property (
        req_fire && req_i.fetch && far_page
        |=> rsp_o.refused ##1 !rsp_o.refused || rsp_o.valid)
        else $error("uncacheable fetch beyond next page");

    local_write_a: assert property (
        req_fire && req_i.write && !req_i.fetch
        && (d_st == MESI_M || d_st == MESI_E)
        |=> rsp_o.op == OP_NONE && rsp_o.state == MESI_M)
        else $error("local write went to the bus");

    shared_write_a: assert property (
        req_fire && req_i.write && !req_i.fetch && d_st == MESI_S
        && req_i.promote_ok |=> rsp_o.op == OP_RD_INV)
        else $error("shared write without ownership cycle");

    miss_write_a: assert property (
        req_fire && req_i.write && !req_i.fetch && d_st == MESI_I
        |=> rsp_o.op inside {OP_FILL_WR, OP_MEM_WR})
        else $error("write miss kept off the bus");

    icache_drop_a: assert property (
        req_fire && req_i.write && !req_i.fetch && i_hit
        && !(snp_i.valid) |=> !ival_ff[$past(idx)])
        else $error("instruction line kept after data write");

    nofill_read_a: assert property (
        req_fire && !req_i.write && !req_i.fetch && !d_hit
        && mode_nofill |=> rsp_o.op == OP_MEM_RD && !rsp_o.hit)
        else $error("no-fill read miss replaced a line");

    bad_ctrl_a: assert property (
        bad_ctrl |=> fault_o && $stable(coff_ff) && $stable(wbi_ff)
        ##1 !fault_o || $past(bad_ctrl))
        else $error("invalid flag pair not refused");

    reset_mode_a: assert property (
        $fell(rst_i) |-> mode_o == MODE_NOFILL && !wbi_ff)
        else $error("reset did not select no-fill");

    snoop_nofill_a: assert property (
        snp_i.valid && s_hit && mode_nofill |=> snp_hit_o)
        else $error("snoop ignored while caching is off");

    fetch_state_a: assert property (
        req_fire && req_i.fetch
        |=> rsp_o.state == MESI_S || rsp_o.state == MESI_I)
        else $error("instruction line outside shared or invalid");

    nofill_alloc_a: assert property (
        req_fire && mode_nofill
        |=> rsp_o.op != OP_FILL && rsp_o.op != OP_FILL_WR)
        else $error("no-fill access allocated a line");

    promote_state_a: assert property (
        req_fire && req_i.write && !req_i.fetch && d_st == MESI_S
        && req_i.promote_ok
        |=> rsp_o.state == ($past(mode_nofill) ? MESI_E : MESI_M))
        else $error("shared write hit promoted to the wrong state");

    mode_track_a: assert property (
        ctrl_wr && !bad_ctrl |=> (mode_o == MODE_NOFILL)
        == $past(wb_dat_i[COFF_BIT]))
        else $error("mode did not follow the flag write");

    shared_cov: cover property (
        req_fire && req_i.write && d_st == MESI_S ##1 rsp_o.valid);
    hitm_cov: cover property (snp_hitm_o);
    fault_cov: cover property (fault_o);
    refuse_cov: cover property (rsp_o.refused);
endmodule // ccm_cache_ctrl

// ==== hdl/ccm_pkg.sv ====
package ccm_pkg;
    localparam int ADDR_W = 32;
    localparam int LINE_BITS = 6;
    localparam int PAGE_BITS = 12;
    localparam int PG_W = ADDR_W - PAGE_BITS;
    localparam int WB_AW = 8;

    localparam logic [WB_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [WB_AW-1:0] REG_CFG = 8'h04;
    localparam logic [WB_AW-1:0] REG_INV = 8'h08;
    localparam logic [WB_AW-1:0] REG_STAT = 8'h0c;

    localparam int COFF_BIT = 30;
    localparam int WBI_BIT = 29;
    localparam int CFG_RT_EN = 0;
    localparam int CFG_ALL_UNC = 1;
    localparam int INV_ALL = 0;
    localparam int ST_NOFILL = 0;
    localparam int ST_STRICT = 1;
    localparam int ST_FCNT = 8;

    localparam logic COFF_RST = 1'h1;
    localparam logic WBI_RST = 1'h0;
    localparam logic RT_EN_RST = 1'h1;
    localparam logic ALL_UNC_RST = 1'h0;
    localparam logic [15:0] FAULT_CODE = 16'h0000;

    typedef enum logic [1:0] {
        MESI_I = 2'h0,
        MESI_S = 2'h1,
        MESI_E = 2'h3,
        MESI_M = 2'h2
    } ccm_mesi_t;

    typedef enum logic {
        MODE_NORMAL = 1'h0,
        MODE_NOFILL = 1'h1
    } ccm_mode_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_MEM_RD = 3'h1,
        OP_FILL = 3'h3,
        OP_FILL_WR = 3'h2,
        OP_MEM_WR = 3'h6,
        OP_RD_INV = 3'h7
    } ccm_op_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        logic spec;
        logic extra;
        logic uncached;
        logic promote_ok;
        logic [ADDR_W-1:0] addr;
    } ccm_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic refused;
        ccm_op_t op;
        ccm_mesi_t state;
    } ccm_rsp_t;

    typedef struct packed {
        logic valid;
        logic inv;
        logic [ADDR_W-1:0] addr;
    } ccm_snp_t;
endpackage : ccm_pkg

// ==== tb/ccm_bus_model.sv ====
module ccm_bus_model
    import ccm_pkg::*;
(
    input wire logic clk_i,
    output ccm_pkg::ccm_snp_t snp_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial snp_o = '0;

    // Released bus shows a changed address, never the stale one
    task automatic snoop(input logic inv, input logic [31:0] a);
        @(posedge clk_i);
        snp_o <= {1'b1, inv, a};
        @(posedge clk_i);
        snp_o <= {1'b0, 1'b0, ~a};
    endtask
endmodule // ccm_bus_model

// ==== tb/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ccm_pkg::*;

    localparam logic [31:0] A = 32'h0000_1000;
    localparam logic [31:0] B = 32'h0000_1040;
    localparam logic [31:0] C = 32'h0000_1080;
    localparam logic [31:0] D = 32'h0000_10c0;

    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [WB_AW-1:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic wb_ack_o, req_ready_o, snp_hit_o, snp_hitm_o, fault_o;
    logic strict_order_o, fault_seen;
    logic [15:0] fault_code_o;
    ccm_req_t req_i;
    ccm_rsp_t rsp_o;
    ccm_snp_t snp_i;
    ccm_mode_t mode_o;
    int mismatches = 0;
    int total_checks = 0;

    ccm_cache_ctrl #(.LINES(4)) uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .req_i, .req_ready_o, .rsp_o, .snp_i, .snp_hit_o, .snp_hitm_o,
        .fault_o, .fault_code_o, .mode_o, .strict_order_o);
    ccm_bus_model u_bus (.clk_i, .snp_o(snp_i));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input string n, input logic [31:0] e,
                           input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    task automatic chk_rsp(input ccm_rsp_t e);
        total_checks++;
        if (rsp_o !== e) begin
            mismatches++;
            $display("unexpected rsp_o: expected %h, seen %h", e, rsp_o);
        end
    endtask

    // Values are read at the edge itself, before its updates land
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // Only the watchdog ends a hung wait
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        chk_val("wb_latency", 32'h2, n);
        rd = wb_dat_o;
        fault_seen = fault_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        chk_val("wb_ack_o", 32'h0, {31'h0, wb_ack_o});
    endtask

    // Flags: write, fetch, spec, extra, uncached, promote_ok
    task automatic rq(input logic [5:0] f, input logic [31:0] a,
                      input ccm_rsp_t e);
        @(posedge clk_i);
        req_i <= {1'b1, f, a};
        do begin
            @(posedge clk_i);
        end while (req_ready_o !== 1'b1);
        req_i.valid <= 1'b0;
        @(posedge clk_i);
        chk_rsp(e);
    endtask

    task automatic snp(input logic inv, input logic [31:0] a,
                       input logic hit, input logic hitm);
        u_bus.snoop(inv, a);
        @(posedge clk_i);
        chk_val("snp_hit_o", {31'h0, hit}, {31'h0, snp_hit_o});
        chk_val("snp_hitm_o", {31'h0, hitm}, {31'h0, snp_hitm_o});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk_val("mode_o", MODE_NOFILL, mode_o);
        chk_val("strict_order_o", 32'h0, {31'h0, strict_order_o});
        wb(1'b0, REG_CTRL, 32'h0);
        chk_val("ctrl", 32'h4000_0000, rd);
        wb(1'b0, REG_STAT, 32'h0);
        chk_val("stat", 32'h0000_0001, rd);
        wb(1'b0, 8'h40, 32'h0);
        chk_val("unmapped", 32'h0, rd);
        $display("test reset done");
    endtask

    task automatic t_normal;
        wb(1'b1, REG_CTRL, 32'h0);
        chk_val("fault_o", 32'h0, {31'h0, fault_seen});
        chk_val("mode_o", MODE_NORMAL, mode_o);
        rq(6'h00, A, {3'b100, OP_FILL, MESI_E});
        rq(6'h00, A, {3'b110, OP_NONE, MESI_E});
        rq(6'h20, A, {3'b110, OP_NONE, MESI_M});
        snp(1'b0, A, 1'b1, 1'b1);
        rq(6'h20, A, {3'b110, OP_MEM_WR, MESI_S});
        rq(6'h21, A, {3'b110, OP_RD_INV, MESI_M});
        rq(6'h20, B, {3'b100, OP_FILL_WR, MESI_E});
        snp(1'b1, B, 1'b1, 1'b0);
        rq(6'h20, B, {3'b100, OP_FILL_WR, MESI_E});
        rq(6'h10, C, {3'b100, OP_FILL, MESI_S});
        rq(6'h10, C, {3'b110, OP_NONE, MESI_S});
        rq(6'h20, C, {3'b100, OP_FILL_WR, MESI_E});
        rq(6'h10, C, {3'b100, OP_FILL, MESI_S});
        $display("test normal done");
    endtask

    task automatic t_fault;
        wb(1'b1, REG_CTRL, 32'h2000_0000);
        chk_val("fault_o", 32'h1, {31'h0, fault_seen});
        chk_val("fault_code_o", 32'h0, {16'h0, fault_code_o});
        chk_val("mode_o", MODE_NORMAL, mode_o);
        wb(1'b0, REG_STAT, 32'h0);
        chk_val("stat", 32'h0000_0100, rd);
        $display("test fault done");
    endtask

    task automatic t_nofill;
        snp(1'b0, C, 1'b1, 1'b0);
        wb(1'b1, REG_CTRL, 32'h4000_0000);
        chk_val("mode_o", MODE_NOFILL, mode_o);
        rq(6'h21, C, {3'b110, OP_RD_INV, MESI_E});
        rq(6'h20, C, {3'b110, OP_NONE, MESI_M});
        snp(1'b1, C, 1'b1, 1'b1);
        rq(6'h00, D, {3'b100, OP_MEM_RD, MESI_I});
        rq(6'h00, D, {3'b100, OP_MEM_RD, MESI_I});
        rq(6'h20, D, {3'b100, OP_MEM_WR, MESI_I});
        // Flush after caching-off so stale lines cannot be hit
        wb(1'b1, REG_INV, 32'h1);
        rq(6'h00, A, {3'b100, OP_MEM_RD, MESI_I});
        $display("test nofill done");
    endtask

    task automatic t_strict;
        wb(1'b1, REG_CFG, 32'h0);
        chk_val("strict", 32'h1, {31'h0, strict_order_o});
        wb(1'b0, REG_STAT, 32'h0);
        chk_val("stat", 32'h0000_0103, rd);
        wb(1'b1, REG_CFG, 32'h3);
        chk_val("strict", 32'h1, {31'h0, strict_order_o});
        wb(1'b1, REG_CFG, 32'h1);
        chk_val("strict", 32'h0, {31'h0, strict_order_o});
        $display("test strict done");
    endtask

    task automatic t_fetch;
        rq(6'h1a, 32'h0000_5000, {3'b101, OP_NONE, MESI_I});
        rq(6'h12, 32'h0000_5000, {3'b100, OP_MEM_RD, MESI_I});
        rq(6'h16, 32'h0000_5040, {3'b100, OP_MEM_RD, MESI_I});
        rq(6'h16, 32'h0000_6000, {3'b100, OP_MEM_RD, MESI_I});
        rq(6'h16, 32'h0000_7000, {3'b101, OP_NONE, MESI_I});
        $display("test fetch done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        $display("unexpected run length: expected under 5000, seen 5000");
        complete_run;
    end

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = '0;
        wb_sel_i = 4'hf;
        wb_dat_i = '0;
        req_i = '0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_normal;
        t_fault;
        t_nofill;
        t_strict;
        t_fetch;
        complete_run;
    end
endmodule // tb
